/* File: rtl/dps_defines.svh */
// Constants for the dual synthesizer serial programming block.
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
`define DPS_WORD_W 23
`define DPS_DEST_LSB 0
`define DPS_DEST_W 2
`define DPS_REF_LSB 2
`define DPS_REF_W 14
`define DPS_CUR_BIT 16
`define DPS_MON_SEL_BIT 17
`define DPS_A_LSB 2
`define DPS_A_W 7
`define DPS_B_LSB 9
`define DPS_B_W 11
`define DPS_MOD_BIT 20
`define DPS_POL_BIT 21
`define DPS_REF_MIN 14'h0003
`define DPS_MAIN_MIN 11'h003
`define DPS_LOW_P_SMALL 8'h08
`define DPS_LOW_P_BIG 8'h10
`define DPS_HIGH_P_SMALL 8'h40
`define DPS_HIGH_P_BIG 8'h80
`define DPS_OFS_LREF 8'h00
`define DPS_OFS_LPROG 8'h04
`define DPS_OFS_HREF 8'h08
`define DPS_OFS_HPROG 8'h0c
`define DPS_OFS_STATUS 8'h10
`define DPS_OFS_CTRL 8'h14
`define DPS_CTRL_RST 1'h1
`define DPS_CLK_NS 100
`define DPS_LOCK_WIN_NS 400
`define DPS_LOCK_WIN_CYC (`DPS_LOCK_WIN_NS / `DPS_CLK_NS)
`endif

/* File: rtl/dps_pkg.sv */
// Types shared by the dual synthesizer programming block.
package dps_pkg;
  typedef enum logic [1:0] {
    DPS_BUS_IDLE = 2'b01,
    DPS_BUS_ACK = 2'b10
  } dps_bus_st_t;
  typedef enum logic [1:0] {
    DPS_DEST_LREF = 2'b00,
    DPS_DEST_LPROG = 2'b01,
    DPS_DEST_HREF = 2'b10,
    DPS_DEST_HPROG = 2'b11
  } dps_dest_t;
endpackage

/* File: rtl/dps_sec_if.sv */
// Configuration and status between the top and one synthesizer section.
interface dps_sec_if;
  logic run;
  logic [13:0] ref_ratio;
  logic [6:0] swallow;
  logic [10:0] main_ratio;
  logic mod_sel;
  logic polarity;
  logic up;
  logic dn;
  logic lock;
  logic ref_pulse;
  logic fb_pulse;
  modport ctrl (output run, ref_ratio, swallow, main_ratio, mod_sel, polarity,
    input up, dn, lock, ref_pulse, fb_pulse);
  modport sect (input run, ref_ratio, swallow, main_ratio, mod_sel, polarity,
    output up, dn, lock, ref_pulse, fb_pulse);
endinterface

/* File: rtl/dps_section.sv */
// One synthesizer section: dividers, phase detector and lock detect.
`include "dps_defines.svh"
module dps_section import dps_pkg::*; #(
  parameter logic HIGH_BAND = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ref_edge,
  input wire logic i_vco_edge,
  dps_sec_if.sect sec
);
  logic [13:0] ref_cnt_q;
  logic [7:0] pre_cnt_q;
  logic [6:0] sw_left_q;
  logic [10:0] main_left_q;
  logic ref_p_q, fb_p_q, up_q, dn_q, lock_q;
  logic [7:0] err_cnt_q;
  logic [17:0] vco_cnt_q;
  logic [32:0] cfg_prev_q;
  logic total_ok_q;

  wire [13:0] ratio = (sec.ref_ratio < `DPS_REF_MIN) ? `DPS_REF_MIN : sec.ref_ratio;
  wire [10:0] b_eff = (sec.main_ratio < `DPS_MAIN_MIN) ? `DPS_MAIN_MIN : sec.main_ratio;
  wire [6:0] a_eff = ({4'h0, sec.swallow} > b_eff) ? b_eff[6:0] : sec.swallow;
  wire [7:0] p_high = sec.mod_sel ? `DPS_HIGH_P_BIG : `DPS_HIGH_P_SMALL;
  wire [7:0] p_low = sec.mod_sel ? `DPS_LOW_P_BIG : `DPS_LOW_P_SMALL;
  wire [7:0] p_base = HIGH_BAND ? p_high : p_low;
  wire [7:0] p_mod = p_base + {7'h0, sw_left_q != 7'h0};
  wire ref_wrap = i_ref_edge && (ref_cnt_q >= ratio - 14'h1);
  wire pre_wrap = i_vco_edge && (pre_cnt_q >= p_mod - 8'h1);
  wire fb_wrap = pre_wrap && (main_left_q <= 11'h1);
  wire up_n = up_q | ref_p_q;
  wire dn_n = dn_q | fb_p_q;
  wire both = up_n & dn_n;
  wire [32:0] cfg_now = {sec.ref_ratio, sec.swallow, sec.main_ratio, sec.mod_sel};
  wire [17:0] total = 18'(p_base) * 18'(b_eff) + 18'(a_eff);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ref_cnt_q <= 14'h0;
      pre_cnt_q <= 8'h0;
    end else if (!sec.run) begin
      ref_cnt_q <= 14'h0;
      pre_cnt_q <= 8'h0;
    end else begin
      if (i_ref_edge) ref_cnt_q <= ref_wrap ? 14'h0 : ref_cnt_q + 14'h1;
      if (i_vco_edge) pre_cnt_q <= pre_wrap ? 8'h0 : pre_cnt_q + 8'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sw_left_q <= 7'h0;
      main_left_q <= 11'h0;
    end else if (!sec.run || fb_wrap) begin
      sw_left_q <= a_eff;
      main_left_q <= b_eff;
    end else if (pre_wrap) begin
      sw_left_q <= (sw_left_q != 7'h0) ? sw_left_q - 7'h1 : 7'h0;
      main_left_q <= main_left_q - 11'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ref_p_q <= 1'b0;
      fb_p_q <= 1'b0;
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      ref_p_q <= ref_wrap & sec.run;
      fb_p_q <= fb_wrap & sec.run;
      up_q <= up_n & ~both & sec.run;
      dn_q <= dn_n & ~both & sec.run;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      err_cnt_q <= 8'h0;
      lock_q <= 1'b0;
    end else if (!sec.run) begin
      err_cnt_q <= 8'h0;
      lock_q <= 1'b0;
    end else if (ref_p_q) begin
      lock_q <= err_cnt_q <= 8'(`DPS_LOCK_WIN_CYC);
      err_cnt_q <= 8'h0;
    end else if ((up_q | dn_q) && err_cnt_q != 8'hff) begin
      err_cnt_q <= err_cnt_q + 8'h1;
    end
  end

  assign sec.up = sec.polarity ? dn_q : up_q;
  assign sec.dn = sec.polarity ? up_q : dn_q;
  assign sec.lock = lock_q;
  assign sec.ref_pulse = ref_p_q;
  assign sec.fb_pulse = fb_p_q;

  // Helper counts prescaler input edges between two feedback pulses.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      vco_cnt_q <= 18'h0;
      cfg_prev_q <= 33'h0;
      total_ok_q <= 1'b0;
    end else begin
      cfg_prev_q <= cfg_now;
      if (!sec.run || fb_wrap) vco_cnt_q <= 18'h0;
      else if (i_vco_edge) vco_cnt_q <= vco_cnt_q + 18'h1;
      if (!sec.run || cfg_now != cfg_prev_q) total_ok_q <= 1'b0;
      else if (fb_wrap) total_ok_q <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  fb_total_a: assert property (fb_wrap && total_ok_q |-> vco_cnt_q + 18'h1 == total)
    else $error("Feedback division differs from base times main plus swallow.");
  pre_mod_a: assert property (pre_wrap && sw_left_q != 7'h0 |-> pre_cnt_q == p_base)
    else $error("Prescaler did not use the upper modulus while swallowing.");
  ref_div_a: assert property (sec.run && ref_wrap |=> sec.ref_pulse ##1 !sec.ref_pulse)
    else $error("Reference divider wrap gave no single pulse.");
  pol_inv_a: assert property (sec.run && sec.polarity && $rose(up_q) |-> sec.dn)
    else $error("Inverted polarity did not swap the detector outputs.");
  cover property (sec.lock);
endmodule

/* File: rtl/dps_top.sv */
// Serial programming, latches, bus slave and outputs of the dual synthesizer.
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`include "dps_defines.svh"
module dps_top import dps_pkg::*; (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst,
  // Serial programming link.
  input wire logic i_serial_clock,
  input wire logic i_serial_data,
  input wire logic i_load_strobe,
  // Power save pins.
  input wire logic i_low_band_power_save_n,
  input wire logic i_high_band_power_save_n,
  // Frequency inputs.
  input wire logic i_reference_osc_input,
  input wire logic i_low_band_vco,
  input wire logic i_high_band_vco,
  // Charge pump outputs.
  output logic o_low_pump,
  output logic o_low_pump_oe,
  output logic o_low_pump_hi_current,
  output logic o_high_pump,
  output logic o_high_pump_oe,
  output logic o_high_pump_hi_current,
  // Shared lock or monitor output.
  output logic o_lock_indicator,
  // Avalon-MM slave.
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  // Link domain shift register.
  logic [`DPS_WORD_W-1:0] shift_q;

  always_ff @(posedge i_serial_clock or posedge i_rst) begin
    if (i_rst) begin
      shift_q <= '0;
    end else begin
      shift_q <= {shift_q[`DPS_WORD_W-2:0], i_serial_data};
    end
  end

  // Synchronisers for pins: strobe, power saves, reference and both prescaler inputs.
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] sync3_q;
  wire [5:0] pins = {i_load_strobe, i_low_band_power_save_n, i_high_band_power_save_n,
    i_reference_osc_input, i_low_band_vco, i_high_band_vco};

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      sync3_q <= 6'h00;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  wire strobe_s = sync2_q[5];
  wire low_run = sync2_q[4];
  wire high_run = sync2_q[3];
  wire ref_edge = sync2_q[2] & ~sync3_q[2];
  wire low_vco_edge = sync2_q[1] & ~sync3_q[1];
  wire high_vco_edge = sync2_q[0] & ~sync3_q[0];

  // Control and load handling.
  logic ctrl_q;
  logic [7:0] load_cnt_q;
  logic [`DPS_WORD_W-1:0] lat_q [4];

  // The word is stable while the strobe is high because the link clock stands still.
  wire load_edge = strobe_s & ~sync3_q[5] & ctrl_q;
  wire [1:0] dest = shift_q[`DPS_DEST_LSB +: `DPS_DEST_W];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 4; i++) begin
        lat_q[i] <= '0;
      end
    end else if (load_edge) begin
      lat_q[dest] <= shift_q;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      load_cnt_q <= 8'h00;
    end else if (load_edge) begin
      load_cnt_q <= load_cnt_q + 8'h01;
    end
  end

  // Field extraction from the latches.
  wire [`DPS_WORD_W-1:0] lref = lat_q[DPS_DEST_LREF];
  wire [`DPS_WORD_W-1:0] lprog = lat_q[DPS_DEST_LPROG];
  wire [`DPS_WORD_W-1:0] href = lat_q[DPS_DEST_HREF];
  wire [`DPS_WORD_W-1:0] hprog = lat_q[DPS_DEST_HPROG];
  wire mon_sel = lref[`DPS_MON_SEL_BIT];

  dps_sec_if low_if ();
  dps_sec_if high_if ();

  assign low_if.run = low_run;
  assign low_if.ref_ratio = lref[`DPS_REF_LSB +: `DPS_REF_W];
  assign low_if.swallow = lprog[`DPS_A_LSB +: `DPS_A_W];
  assign low_if.main_ratio = lprog[`DPS_B_LSB +: `DPS_B_W];
  assign low_if.mod_sel = lprog[`DPS_MOD_BIT];
  assign low_if.polarity = lprog[`DPS_POL_BIT];
  assign high_if.run = high_run;
  assign high_if.ref_ratio = href[`DPS_REF_LSB +: `DPS_REF_W];
  assign high_if.swallow = hprog[`DPS_A_LSB +: `DPS_A_W];
  assign high_if.main_ratio = hprog[`DPS_B_LSB +: `DPS_B_W];
  assign high_if.mod_sel = hprog[`DPS_MOD_BIT];
  assign high_if.polarity = hprog[`DPS_POL_BIT];

  dps_section #(
    .HIGH_BAND(1'b0)
  ) u_low (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ref_edge(ref_edge),
    .i_vco_edge(low_vco_edge),
    .sec(low_if.sect)
  );

  dps_section #(
    .HIGH_BAND(1'b1)
  ) u_high (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ref_edge(ref_edge),
    .i_vco_edge(high_vco_edge),
    .sec(high_if.sect)
  );

  // Output stage.
  logic low_pump_q, low_oe_q, low_cur_q;
  logic high_pump_q, high_oe_q, high_cur_q;
  logic shared_q;
  wire lock_all = (low_if.lock | ~low_run) & (high_if.lock | ~high_run);
  wire monitor = low_if.ref_pulse;
  wire shared_d = mon_sel ? monitor : lock_all;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      low_pump_q <= 1'b0;
      low_oe_q <= 1'b0;
      high_pump_q <= 1'b0;
      high_oe_q <= 1'b0;
    end else begin
      low_pump_q <= low_if.up;
      low_oe_q <= (low_if.up | low_if.dn) & low_run;
      high_pump_q <= high_if.up;
      high_oe_q <= (high_if.up | high_if.dn) & high_run;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      low_cur_q <= 1'b0;
      high_cur_q <= 1'b0;
      shared_q <= 1'b0;
    end else begin
      low_cur_q <= lref[`DPS_CUR_BIT];
      high_cur_q <= href[`DPS_CUR_BIT];
      shared_q <= shared_d;
    end
  end

  assign o_low_pump = low_pump_q;
  assign o_low_pump_oe = low_oe_q;
  assign o_low_pump_hi_current = low_cur_q;
  assign o_high_pump = high_pump_q;
  assign o_high_pump_oe = high_oe_q;
  assign o_high_pump_hi_current = high_cur_q;
  assign o_lock_indicator = shared_q;

  // Avalon-MM slave with one wait cycle.
  dps_bus_st_t bus_q;
  logic wait_q;
  logic [31:0] rdata_q;
  wire bus_req = i_avs_read | i_avs_write;
  wire hit_lref = i_avs_address == `DPS_OFS_LREF;
  wire hit_lprog = i_avs_address == `DPS_OFS_LPROG;
  wire hit_href = i_avs_address == `DPS_OFS_HREF;
  wire hit_hprog = i_avs_address == `DPS_OFS_HPROG;
  wire hit_status = i_avs_address == `DPS_OFS_STATUS;
  wire hit_ctrl = i_avs_address == `DPS_OFS_CTRL;
  wire [31:0] status = {16'h0000, load_cnt_q, 4'h0, high_if.lock, low_if.lock,
    high_run, low_run};
  logic [31:0] rd_mux;

  always_comb begin
    if (hit_lref) begin
      rd_mux = {9'h000, lref};
    end else if (hit_lprog) begin
      rd_mux = {9'h000, lprog};
    end else if (hit_href) begin
      rd_mux = {9'h000, href};
    end else if (hit_hprog) begin
      rd_mux = {9'h000, hprog};
    end else if (hit_status) begin
      rd_mux = status;
    end else if (hit_ctrl) begin
      rd_mux = {31'h0000_0000, ctrl_q};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  wire ctrl_wr = (bus_q == DPS_BUS_ACK) & i_avs_write & hit_ctrl & i_avs_byteenable[0];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bus_q <= DPS_BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      case (bus_q)
        DPS_BUS_IDLE: begin
          if (bus_req) begin
            bus_q <= DPS_BUS_ACK;
            wait_q <= 1'b0;
            rdata_q <= i_avs_read ? rd_mux : 32'h0000_0000;
          end
        end
        DPS_BUS_ACK: begin
          bus_q <= DPS_BUS_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          bus_q <= DPS_BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= `DPS_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= i_avs_writedata[0];
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;

  // Checks.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  shift_in_a: assert property (@(posedge i_serial_clock) disable iff (i_rst)
    1 |=> shift_q[0] == $past(i_serial_data) && shift_q[22:1] == $past(shift_q[21:0]))
    else $error("Shift register did not take the serial bit.");
  latch_load_a: assert property (load_edge |=> lat_q[$past(dest)] == $past(shift_q))
    else $error("Load strobe did not copy the word into its latch.");
  latch_dest_a: assert property (load_edge && dest == 2'b11 |=>
    lat_q[0] == $past(lat_q[0]) && lat_q[2] == $past(lat_q[2]))
    else $error("A load disturbed a latch it did not address.");
  latch_hold_a: assert property (!load_edge |=> lat_q[1] == $past(lat_q[1]))
    else $error("A latch changed without a load.");
  low_save_a: assert property (!low_run |=> !o_low_pump_oe ##1 !o_low_pump_oe)
    else $error("Low band pump drove while in power save.");
  high_save_a: assert property (!high_run |=> !o_high_pump_oe)
    else $error("High band pump drove while in power save.");
  mon_sel_a: assert property (mon_sel |=> o_lock_indicator == $past(monitor))
    else $error("Shared output did not show the monitor signal.");
  lock_sel_a: assert property (!mon_sel |=> o_lock_indicator == $past(lock_all))
    else $error("Shared output did not show the lock signal.");
  pump_cur_a: assert property ($changed(lref[16]) |->
    ##2 o_low_pump_hi_current == lref[16])
    else $error("Pump current select did not follow the latch.");
  high_cur_a: assert property ($changed(href[16]) |->
    ##2 o_high_pump_hi_current == href[16])
    else $error("High band pump current select did not follow the latch.");

  load_count_a: assert property (load_edge |=>
    load_cnt_q == $past(load_cnt_q) + 8'h01)
    else $error("A load was not counted.");
  load_refused_a: assert property (strobe_s && !sync3_q[5] && !ctrl_q |=>
    load_cnt_q == $past(load_cnt_q) && lat_q[0] == $past(lat_q[0]))
    else $error("A load went through while loads were disabled.");
  latch_low_dest_a: assert property (load_edge && dest == 2'b00 |=>
    lat_q[1] == $past(lat_q[1]) && lat_q[3] == $past(lat_q[3]))
    else $error("A low band reference load disturbed another latch.");

  low_sync_a: assert property (low_run == $past(i_low_band_power_save_n, 2))
    else $error("Low band power save pin did not pass two flip-flops.");
  high_sync_a: assert property (high_run == $past(i_high_band_power_save_n, 2))
    else $error("High band power save pin did not pass two flip-flops.");
  low_drive_a: assert property (low_run && low_if.up |=>
    o_low_pump && o_low_pump_oe)
    else $error("Running low band pump did not source.");
  low_sink_a: assert property (low_run && low_if.dn |=>
    !o_low_pump && o_low_pump_oe)
    else $error("Running low band pump did not sink.");
  high_drive_a: assert property (high_run && high_if.up |=>
    o_high_pump && o_high_pump_oe)
    else $error("Running high band pump did not source.");
  high_sink_a: assert property (high_run && high_if.dn |=>
    !o_high_pump && o_high_pump_oe)
    else $error("Running high band pump did not sink.");
  lock_asleep_a: assert property (!mon_sel && !low_run && !high_run |=>
    o_lock_indicator)
    else $error("Sleeping sections did not count as locked.");

  bus_answer_a: assert property (bus_q == DPS_BUS_IDLE && bus_req |=> !o_avs_waitrequest)
    else $error("Bus request was not answered after one wait cycle.");
  bus_wait_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("Waitrequest stayed low for more than one cycle.");
  ctrl_write_a: assert property (ctrl_wr |=> ctrl_q == $past(i_avs_writedata[0]))
    else $error("Control write did not take effect.");
  read_latch_a: assert property (bus_q == DPS_BUS_IDLE && i_avs_read && hit_hprog |=>
    o_avs_readdata == {9'h000, $past(hprog)})
    else $error("Read data did not show the high band programmable latch.");
  status_read_a: assert property (bus_q == DPS_BUS_IDLE && i_avs_read && hit_status |=>
    o_avs_readdata[15:8] == $past(load_cnt_q))
    else $error("Status read did not show the load count.");

  cover property (load_edge && dest == 2'b11);
  cover property (o_lock_indicator && !mon_sel && low_run && high_run);
  cover property (ctrl_wr ##1 load_cnt_q != 8'h00);
  cover property (load_edge && dest == 2'b00 && shift_q[`DPS_MON_SEL_BIT]);
endmodule

/* File: verification/dps_host_model.sv */
// Host controller model that drives the serial programming link and power save pins.
module dps_host_model (
  // Serial programming link.
  output logic o_serial_clock,
  output logic o_serial_data,
  output logic o_load_strobe,
  // Power save pins.
  output logic o_low_band_power_save_n,
  output logic o_high_band_power_save_n
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_serial_clock = 1'b0;
    o_serial_data = 1'b1;
    o_load_strobe = 1'b0;
    o_low_band_power_save_n = 1'b0;
    o_high_band_power_save_n = 1'b0;
  end

  // Sets both power save pins, always to a driven level.
  task automatic set_power(input logic lo, input logic hi);
    o_low_band_power_save_n <= lo;
    o_high_band_power_save_n <= hi;
  endtask

  // Shifts one word, first bit first, with a 160 ns link clock.
  task automatic send_word(input logic [22:0] w);
    for (int i = 22; i >= 0; i--) begin
      o_serial_data = w[i];
      #80;
      o_serial_clock = 1'b1;
      #80;
      o_serial_clock = 1'b0;
    end
    // The released data line shows the opposite of its last bit.
    o_serial_data = ~w[0];
    #450;
    o_load_strobe = 1'b1;
    #650;
    o_load_strobe = 1'b0;
    #500;
  endtask
endmodule

/* File: verification/dual_pll_serial_program_tb.sv */
// Self-checking testbench for the dual synthesizer programming block.
module dual_pll_serial_program_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clock, i_rst, sclk, sdata, strobe, ps_lo, ps_hi;
  logic ref_osc, low_vco, high_vco;
  logic o_low_pump, o_low_pump_oe, o_low_hi, o_high_pump, o_high_pump_oe, o_high_hi;
  logic o_lock_indicator, o_avs_waitrequest;
  logic [7:0] avs_address;
  logic avs_read, avs_write;
  logic [31:0] avs_writedata, o_avs_readdata, rd;
  logic [22:0] words [4];
  int n_fail, comparisons, pulses;

  dps_host_model host_u (
    .o_serial_clock(sclk), .o_serial_data(sdata), .o_load_strobe(strobe),
    .o_low_band_power_save_n(ps_lo), .o_high_band_power_save_n(ps_hi)
  );

  dps_top dut_u (
    .i_clock(i_clock), .i_rst(i_rst),
    .i_serial_clock(sclk), .i_serial_data(sdata), .i_load_strobe(strobe),
    .i_low_band_power_save_n(ps_lo), .i_high_band_power_save_n(ps_hi),
    .i_reference_osc_input(ref_osc), .i_low_band_vco(low_vco), .i_high_band_vco(high_vco),
    .o_low_pump(o_low_pump), .o_low_pump_oe(o_low_pump_oe), .o_low_pump_hi_current(o_low_hi),
    .o_high_pump(o_high_pump), .o_high_pump_oe(o_high_pump_oe),
    .o_high_pump_hi_current(o_high_hi), .o_lock_indicator(o_lock_indicator),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest)
  );

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  initial begin
    ref_osc = 1'b0;
    #13;
    forever #400 ref_osc = ~ref_osc;
  end
  initial begin
    low_vco = 1'b0;
    high_vco = 1'b0;
    #27;
    forever begin
      #350;
      low_vco = ~low_vco;
      high_vco = ~high_vco;
    end
  end

  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // One bus cycle; holds the request until waitrequest is sampled low.
  task automatic bus_cycle(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    d = o_avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      $display("wrong value waitrequest expected 0 seen %b", o_avs_waitrequest);
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    bus_cycle(1'b0, a, 32'h0000_0000, d);
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] unused;
    bus_cycle(1'b1, a, wd, unused);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  initial begin
    n_fail = 0;
    comparisons = 0;
    i_rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    words[0] = 23'h01000c;
    words[1] = 23'h10c815;
    words[2] = 23'h00fffe;
    words[3] = 23'h2fffff;
    cycles(5);
    i_rst <= 1'b0;
    cycles(2);
    bus_read(8'h14, rd);
    chk("ctrl after reset", 32'h0000_0001, rd);
    bus_read(8'h10, rd);
    chk("status after reset", 32'h0000_0000, rd);
    for (int d = 0; d < 4; d++) begin
      bus_read(8'(d * 4), rd);
      chk("latch after reset", 32'h0000_0000, rd);
    end
    bus_write(8'h20, 32'h1234_5678);
    bus_read(8'h20, rd);
    chk("unmapped read", 32'h0000_0000, rd);
    // Each destination code loads its own latch with the whole word.
    for (int d = 0; d < 4; d++) begin
      host_u.send_word(words[d]);
    end
    for (int d = 0; d < 4; d++) begin
      bus_read(8'(d * 4), rd);
      chk("latch word", {9'h000, words[d]}, rd);
    end
    bus_read(8'h10, rd);
    chk("load count", 32'h0000_0400, rd & 32'h0000_ff00);
    cycles(2);
    chk("low pump current", 32'h1, {31'h0, o_low_hi});
    chk("high pump current", 32'h0, {31'h0, o_high_hi});
    chk("lock pin asleep", 32'h1, {31'h0, o_lock_indicator});
    // Loads are refused while the load enable bit is clear.
    bus_write(8'h14, 32'h0000_0000);
    host_u.send_word(23'h00000c);
    bus_read(8'h00, rd);
    chk("refused load", {9'h000, words[0]}, rd);
    bus_write(8'h14, 32'h0000_0001);
    // Each section follows only its own power save pin.
    host_u.set_power(1'b1, 1'b0);
    cycles(5);
    bus_read(8'h10, rd);
    chk("low runs alone", 32'h1, rd & 32'h3);
    host_u.set_power(1'b0, 1'b1);
    cycles(5);
    bus_read(8'h10, rd);
    chk("high runs alone", 32'h2, rd & 32'h3);
    host_u.set_power(1'b1, 1'b1);
    cycles(5);
    bus_read(8'h10, rd);
    chk("both run", 32'h3, rd & 32'h3);
    // Monitor select shows one pulse per reference division of three.
    host_u.send_word(23'h03000c);
    pulses = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge i_clock);
      if (o_lock_indicator === 1'b1) begin
        pulses++;
      end
    end
    comparisons++;
    if (pulses < 10 || pulses > 15) begin
      $display("wrong value monitor pulses expected 12 seen %0d", pulses);
      n_fail++;
    end
    bus_read(8'h10, rd);
    chk("count and run", 32'h0000_0503, rd & 32'h0000_ff03);
    // The reference runs far ahead of the feedback, so the low band pump sources.
    chk("low pump level", 32'h1, {31'h0, o_low_pump});
    chk("low pump drive", 32'h1, {31'h0, o_low_pump_oe});
    host_u.send_word(23'h30c815);
    chk("inverted pump level", 32'h0, {31'h0, o_low_pump});
    chk("inverted pump drive", 32'h1, {31'h0, o_low_pump_oe});
    host_u.set_power(1'b0, 1'b0);
    cycles(5);
    chk("low pump asleep", 32'h0, {31'h0, o_low_pump_oe});
    chk("high pump asleep", 32'h0, {31'h0, o_high_pump_oe});
    chk("high pump level", 32'h0, {31'h0, o_high_pump});
    end_of_test();
  end

  initial begin
    #5ms;
    $display("wrong value run time expected done seen hang");
    n_fail++;
    end_of_test();
  end
endmodule
